/* rtl/addr_debug_unit.sv */
// Effective address generation, address space checks and debug breakpoint unit
//
// Function
// - Trace flag set raises a debug exception after each completed instruction.
// - Breakpoint trap instruction, vector 3, raises a debug exception.
// - All four hit flags set on exception when conditions match, enabled or not.
// - Task-switch trap flag set when switching into a task with its trap bit.
// - Single-step flag set when exception caused by trace single-step.
// - Break type: 00 execute, 01 data write, 11 data read or write, 10 unused.
// - Break length: 00 one byte, 01 two bytes, 11 four bytes, 10 unused.
// - Global enable keeps breakpoint armed for all tasks across task switches.
// - Local enable arms for current task and clears on every task switch.
// - Guard bit set blocks all access to the debug registers.
// - Guard bit clears automatically whenever any debug exception is taken.
// - Byte, word and doubleword accesses anywhere in a 4 GB memory space.
// - Multibyte operands little endian; lowest byte address is the operand address.
// - I/O instructions reach a 64 KB port space through 8, 16, 32-bit ports.
// - Byte accesses to ports 22h and 23h decode as configuration register access path.
// - Offset is the sum of present parts; base is any general register.
// - Stack pointer can never be selected as the index register.
// - Index is multiplied by scale 1, 2, 4 or 8 before summing.
// - Displacement comes from the instruction and is up to 32 bits.
// - Nine addressing combinations of base, index, scale and displacement supported.
// - Execution breakpoints are taken before the matching instruction executes.
`timescale 1ns/10ps
`include "addr_debug_consts.svh"
module addr_debug_unit
	import addr_debug_pkg::*;
#(
	parameter int NUM_BP = 4
)
(
	input  wire logic         mclk,
	input  wire logic         rst_n,
	// Effective address request from the pipeline
	input  wire logic         ea_req,
	input  wire ea_mode_t     ea_mode,
	input  wire logic [2:0]   ea_base_sel,
	input  wire logic [2:0]   ea_index_sel,
	input  wire logic [1:0]   index_multiplier,
	input  wire logic [31:0]  instruction_displacement,
	input  wire logic [255:0] gpr_values,
	output logic              ea_done,
	output logic [31:0]       effective_offset,
	output logic              ea_index_fault,
	// Linear memory access (fetch or data) from the bus unit
	input  wire logic         acc_valid,
	input  wire acc_kind_t    acc_kind,
	input  wire logic [31:0]  acc_addr,
	input  wire logic [2:0]   acc_size,
	output logic              mem_done,
	output logic [31:0]       mem_phys_addr,
	output logic [7:0]        mem_byte_en,
	output logic              mem_split,
	output logic              mem_size_fault,
	// Port access
	input  wire logic         io_valid,
	input  wire logic [31:0]  io_port,
	input  wire logic [2:0]   io_size,
	output logic              io_done,
	output logic              io_range_fault,
	output logic              io_cfg_index_sel,
	output logic              io_cfg_data_sel,
	// Instruction and task events
	input  wire logic         insn_retire,
	input  wire logic         trace_flag,
	input  wire logic         swint_valid,
	input  wire logic [7:0]   swint_vector,
	input  wire logic         task_switch,
	input  wire logic         task_trap_bit,
	// Debug register moves
	input  wire logic         dr_wr,
	input  wire logic         dr_rd,
	input  wire logic [2:0]   dr_sel,
	input  wire logic [31:0]  dr_wdata,
	output logic              dr_ack,
	output logic [31:0]       dr_rdata,
	output logic              dr_guard_fault,
	// Debug exception report
	output logic              debug_exc,
	output logic              debug_exc_before,
	output logic [31:0]       debug_cause_status
);
	typedef struct packed {
		logic [NUM_BP-1:0][31:0] bp_addr;
		logic [31:0]             status;
		logic [31:0]             ctl;
		logic [NUM_BP-1:0]       hit_seen;
		logic                    data_pend;
		logic                    ea_done;
		logic [31:0]             ea_off;
		logic                    ea_idx_fault;
		logic                    mem_done;
		logic [31:0]             mem_addr;
		logic [7:0]              mem_be;
		logic                    mem_split;
		logic                    mem_size_fault;
		logic                    io_done;
		logic                    io_fault;
		logic                    io_cfg_idx;
		logic                    io_cfg_dat;
		logic                    dr_ack;
		logic [31:0]             dr_rdata;
		logic                    dr_fault;
		logic                    exc;
		logic                    exc_before;
	} state_t;

	state_t            state_reg;
	state_t            state_next;
	logic [31:0]       offset_comb;
	logic              idx_fault_comb;
	logic [NUM_BP-1:0] hit_raw;
	logic [NUM_BP-1:0] bp_enabled;

	access_if acc_bus ();
	assign acc_bus.valid = acc_valid;
	assign acc_bus.kind  = acc_kind;
	assign acc_bus.addr  = acc_addr;
	assign acc_bus.size  = acc_size;

	offset_gen u_offset_gen (
		.mode                     (ea_mode),
		.base_sel                 (ea_base_sel),
		.index_sel                (ea_index_sel),
		.index_multiplier         (index_multiplier),
		.instruction_displacement (instruction_displacement),
		.gpr_values               (gpr_values),
		.effective_offset         (offset_comb),
		.index_fault              (idx_fault_comb)
	);

	// Comparators run regardless of the enables so hit flags can be reported for idle breakpoints
	for (genvar i = 0; i < NUM_BP; i++) begin : g_bp
		bp_match u_bp_match (
			.bp_addr            (state_reg.bp_addr[i]),
			.break_type_field   (state_reg.ctl[`CTL_TYPE_LSB + i*`CTL_FIELD_STRIDE +: 2]),
			.break_length_field (state_reg.ctl[`CTL_LEN_LSB + i*`CTL_FIELD_STRIDE +: 2]),
			.acc                (acc_bus),
			.hit                (hit_raw[i])
		);
		// Either enable arms the breakpoint
		assign bp_enabled[i] = state_reg.ctl[2*i] | state_reg.ctl[2*i+1];
	end

	logic              dr_access;
	logic              guard_block;
	logic              exec_break;
	logic              data_break;
	logic              trap_break;
	logic              step_cause;
	logic              task_cause;
	logic              any_exc;
	logic [NUM_BP-1:0] hits_now;
	logic [31:0]       status_set;
	logic [31:0]       rd_val;
	logic [7:0]        lane_mask;

	always_comb begin
		state_next = state_reg;
		hits_now   = hit_raw;

		// Address generation result, one cycle after the request
		state_next.ea_done      = ea_req;
		state_next.ea_off       = ea_req ? offset_comb : state_reg.ea_off;
		state_next.ea_idx_fault = ea_req && idx_fault_comb;

		// Memory access: lowest byte address is the operand address, lanes run upward
		case (acc_size)
			3'h1:    lane_mask = 8'h01;
			3'h2:    lane_mask = 8'h03;
			3'h4:    lane_mask = 8'h0F;
			default: lane_mask = 8'h00;
		endcase
		state_next.mem_done       = acc_valid;
		state_next.mem_size_fault = acc_valid && (lane_mask == 8'h00);
		if (acc_valid) begin
			state_next.mem_addr  = acc_addr;
			state_next.mem_be    = lane_mask << acc_addr[1:0];
			state_next.mem_split = |((lane_mask << acc_addr[1:0]) & 8'hF0);
		end

		// Port space: the whole access must fit below the 64 KB limit
		state_next.io_done    = io_valid;
		// The plain port check stops a sum that wraps past the top of the 32-bit range from passing
		state_next.io_fault   = io_valid && ((io_port > `IO_PORT_MAX)
			|| ((io_port + {29'h0000_0000, io_size} - 32'h0000_0001) > `IO_PORT_MAX)
			|| !((io_size == 3'h1) || (io_size == 3'h2) || (io_size == 3'h4)));
		state_next.io_cfg_idx = io_valid && (io_port == `IO_CFG_INDEX_PORT) && (io_size == 3'h1);
		state_next.io_cfg_dat = io_valid && (io_port == `IO_CFG_DATA_PORT) && (io_size == 3'h1);

		// Debug register moves are refused while the guard is set
		dr_access   = dr_wr || dr_rd;
		guard_block = dr_access && state_reg.ctl[`CTL_GUARD_BIT];

		// Execution break fires on the fetch, before the instruction runs
		exec_break = acc_valid && (acc_kind == ACC_EXEC) && |(hit_raw & bp_enabled);
		data_break = state_reg.data_pend
			|| (acc_valid && (acc_kind != ACC_EXEC) && |(hit_raw & bp_enabled));
		step_cause = insn_retire && trace_flag;
		trap_break = swint_valid && (swint_vector == `BREAK_TRAP_VECTOR);
		task_cause = task_switch && task_trap_bit;
		any_exc    = guard_block || exec_break || trap_break || task_cause || step_cause
			|| (insn_retire && data_break);

		// Data hits wait for the instruction to finish and then trap
		if (insn_retire || any_exc) begin
			state_next.data_pend = 1'b0;
		end else if (data_break) begin
			state_next.data_pend = 1'b1;
		end

		// Hits collect since the last exception, whether enabled or not
		if (any_exc) begin
			state_next.hit_seen = '0;
		end else begin
			state_next.hit_seen = state_reg.hit_seen | hits_now;
		end

		status_set = 32'h0000_0000;
		if (any_exc) begin
			status_set[`STAT_HIT_LSB +: NUM_BP] = state_reg.hit_seen | hits_now;
			status_set[`STAT_STEP_BIT]          = step_cause;
			status_set[`STAT_TASK_BIT]          = task_cause;
		end

		// Software write first, hardware sets on top so a coinciding cause survives
		state_next.status = state_reg.status | status_set;
		if (dr_wr && !guard_block && (dr_sel == `DR_SEL_STATUS)) begin
			state_next.status = (dr_wdata & `STAT_WMASK) | status_set;
		end

		if (dr_wr && !guard_block && (dr_sel == `DR_SEL_CONTROL)) begin
			state_next.ctl = dr_wdata & `CTL_WMASK;
		end
		if (dr_wr && !guard_block && (dr_sel < 3'(NUM_BP))) begin
			state_next.bp_addr[dr_sel[1:0]] = dr_wdata;
		end

		// Local enables belong to the outgoing task; global enables survive
		if (task_switch) begin
			state_next.ctl = state_next.ctl & ~`CTL_LOCAL_MASK;
		end
		// Taking any debug exception reopens the debug registers to the handler
		if (any_exc) begin
			state_next.ctl[`CTL_GUARD_BIT] = 1'b0;
		end

		case (dr_sel)
			3'h0, 3'h1, 3'h2, 3'h3: rd_val = state_reg.bp_addr[dr_sel[1:0]];
			`DR_SEL_STATUS:         rd_val = state_reg.status;
			`DR_SEL_CONTROL:        rd_val = state_reg.ctl;
			default:                rd_val = 32'h0000_0000;
		endcase
		state_next.dr_ack   = dr_access && !guard_block;
		state_next.dr_fault = guard_block;
		if (dr_rd && !guard_block) begin
			state_next.dr_rdata = rd_val;
		end

		state_next.exc        = any_exc;
		state_next.exc_before = guard_block || exec_break;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_reg        <= '0;
			state_reg.status <= `STAT_RESET;
			state_reg.ctl    <= `CTL_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign ea_done            = state_reg.ea_done;
	assign effective_offset   = state_reg.ea_off;
	assign ea_index_fault     = state_reg.ea_idx_fault;
	assign mem_done           = state_reg.mem_done;
	assign mem_phys_addr      = state_reg.mem_addr;
	assign mem_byte_en        = state_reg.mem_be;
	assign mem_split          = state_reg.mem_split;
	assign mem_size_fault     = state_reg.mem_size_fault;
	assign io_done            = state_reg.io_done;
	assign io_range_fault     = state_reg.io_fault;
	assign io_cfg_index_sel   = state_reg.io_cfg_idx;
	assign io_cfg_data_sel    = state_reg.io_cfg_dat;
	assign dr_ack             = state_reg.dr_ack;
	assign dr_rdata           = state_reg.dr_rdata;
	assign dr_guard_fault     = state_reg.dr_fault;
	assign debug_exc          = state_reg.exc;
	assign debug_exc_before   = state_reg.exc_before;
	assign debug_cause_status = state_reg.status;
endmodule // addr_debug_unit

/* common/addr_debug_consts.svh */
// Offsets, field positions, reset values and encodings of the address and debug unit
`ifndef ADDR_DEBUG_CONSTS_SVH
`define ADDR_DEBUG_CONSTS_SVH
`define DR_SEL_STATUS      3'h6
`define DR_SEL_CONTROL     3'h7
`define STAT_HIT_LSB       0
`define STAT_STEP_BIT      14
`define STAT_TASK_BIT      15
`define STAT_RESET         32'h0000_0000
`define STAT_WMASK         32'h0000_C00F
`define CTL_GUARD_BIT      13
`define CTL_TYPE_LSB       16
`define CTL_LEN_LSB        18
`define CTL_FIELD_STRIDE   4
`define CTL_RESET          32'h0000_0000
`define CTL_WMASK          32'hFFFF_20FF
`define CTL_LOCAL_MASK     32'h0000_0055
`define BRK_TYPE_EXEC      2'h0
`define BRK_TYPE_WRITE     2'h1
`define BRK_TYPE_RDWR      2'h3
`define BRK_LEN_1          2'h0
`define BRK_LEN_2          2'h1
`define BRK_LEN_4          2'h3
`define BREAK_TRAP_VECTOR  8'h03
`define GPR_STACK_PTR      3'h4
`define IO_PORT_MAX        32'h0000_FFFF
`define IO_CFG_INDEX_PORT  32'h0000_0022
`define IO_CFG_DATA_PORT   32'h0000_0023
`endif

/* common/addr_debug_pkg.sv */
// Types shared by the address generation and debug breakpoint unit
package addr_debug_pkg;
	typedef enum logic [3:0] {
		EA_DISP           = 4'h0,
		EA_BASE           = 4'h1,
		EA_BASE_DISP      = 4'h2,
		EA_IDX_DISP       = 4'h3,
		EA_SIDX_DISP      = 4'h4,
		EA_BASE_IDX       = 4'h5,
		EA_BASE_SIDX      = 4'h6,
		EA_BASE_IDX_DISP  = 4'h7,
		EA_BASE_SIDX_DISP = 4'h8
	} ea_mode_t;
	typedef enum logic [1:0] {
		ACC_EXEC  = 2'h0,
		ACC_READ  = 2'h1,
		ACC_WRITE = 2'h2
	} acc_kind_t;
endpackage

/* common/access_if.sv */
// Carrier for one memory access as seen by the breakpoint comparators
`timescale 1ns/10ps
interface access_if;
	import addr_debug_pkg::*;
	logic        valid;
	acc_kind_t   kind;
	logic [31:0] addr;
	logic [2:0]  size;
	modport src (output valid, output kind, output addr, output size);
	modport sink (input valid, input kind, input addr, input size);
endinterface

/* rtl/offset_gen.sv */
// Combinational effective offset from base, scaled index and displacement
`timescale 1ns/10ps
`include "addr_debug_consts.svh"
module offset_gen
	import addr_debug_pkg::*;
(
	input  wire ea_mode_t    mode,
	input  wire logic [2:0]  base_sel,
	input  wire logic [2:0]  index_sel,
	input  wire logic [1:0]  index_multiplier,
	input  wire logic [31:0] instruction_displacement,
	input  wire logic [255:0] gpr_values,
	output logic [31:0]      effective_offset,
	output logic             index_fault
);
	logic        use_base;
	logic        use_index;
	logic        use_scale;
	logic        use_disp;
	logic [31:0] base_val;
	logic [31:0] index_val;
	logic [1:0]  shift;

	always_comb begin
		use_base  = 1'b0;
		use_index = 1'b0;
		use_scale = 1'b0;
		use_disp  = 1'b0;
		case (mode)
			EA_DISP:           use_disp = 1'b1;
			EA_BASE:           use_base = 1'b1;
			EA_BASE_DISP:      begin use_base = 1'b1; use_disp = 1'b1; end
			EA_IDX_DISP:       begin use_index = 1'b1; use_disp = 1'b1; end
			EA_SIDX_DISP:      begin use_index = 1'b1; use_scale = 1'b1; use_disp = 1'b1; end
			EA_BASE_IDX:       begin use_base = 1'b1; use_index = 1'b1; end
			EA_BASE_SIDX:      begin use_base = 1'b1; use_index = 1'b1; use_scale = 1'b1; end
			EA_BASE_IDX_DISP:  begin use_base = 1'b1; use_index = 1'b1; use_disp = 1'b1; end
			EA_BASE_SIDX_DISP: begin use_base = 1'b1; use_index = 1'b1; use_scale = 1'b1; use_disp = 1'b1; end
			default:           use_disp = 1'b0;
		endcase
		base_val    = use_base ? gpr_values[base_sel*32 +: 32] : 32'h0000_0000;
		// Stack pointer never serves as index; it contributes nothing and is flagged
		index_fault = use_index && (index_sel == `GPR_STACK_PTR);
		index_val   = (use_index && !index_fault) ? gpr_values[index_sel*32 +: 32] : 32'h0000_0000;
		shift       = use_scale ? index_multiplier : 2'h0;
		effective_offset = base_val + (index_val << shift)
			+ (use_disp ? instruction_displacement : 32'h0000_0000);
	end
endmodule // offset_gen

/* rtl/bp_match.sv */
// One address breakpoint comparator: type, length and overlap check
`timescale 1ns/10ps
`include "addr_debug_consts.svh"
module bp_match
	import addr_debug_pkg::*;
(
	input  wire logic [31:0] bp_addr,
	input  wire logic [1:0]  break_type_field,
	input  wire logic [1:0]  break_length_field,
	access_if.sink           acc,
	output logic             hit
);
	logic        type_ok;
	logic        len_ok;
	logic [32:0] bp_lo;
	logic [32:0] bp_hi;
	logic [32:0] acc_lo;
	logic [32:0] acc_hi;

	always_comb begin
		case (break_type_field)
			`BRK_TYPE_EXEC:  type_ok = (acc.kind == ACC_EXEC);
			`BRK_TYPE_WRITE: type_ok = (acc.kind == ACC_WRITE);
			`BRK_TYPE_RDWR:  type_ok = (acc.kind == ACC_READ) || (acc.kind == ACC_WRITE);
			default:         type_ok = 1'b0;
		endcase
		len_ok = 1'b1;
		case (break_length_field)
			`BRK_LEN_1: bp_lo = {1'b0, bp_addr};
			`BRK_LEN_2: bp_lo = {1'b0, bp_addr[31:1], 1'b0};
			`BRK_LEN_4: bp_lo = {1'b0, bp_addr[31:2], 2'h0};
			default:    begin bp_lo = {1'b0, bp_addr}; len_ok = 1'b0; end
		endcase
		bp_hi  = bp_lo + {31'h0000_0000, break_length_field};
		acc_lo = {1'b0, acc.addr};
		acc_hi = acc_lo + {30'h0000_0000, acc.size} - 33'h0_0000_0001;
		// Any overlap of the access with the watched bytes counts as a hit
		hit = acc.valid && type_ok && len_ok && (acc_lo <= bp_hi) && (bp_lo <= acc_hi);
	end
endmodule // bp_match

/* test/adu_props.sv */
// Port-level checker for the address and debug unit
`timescale 1ns/10ps
`include "addr_debug_consts.svh"
module adu_props
	import addr_debug_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        ea_req,
	input wire ea_mode_t    ea_mode,
	input wire logic [2:0]  ea_index_sel,
	input wire logic [31:0] instruction_displacement,
	input wire logic        ea_done,
	input wire logic [31:0] effective_offset,
	input wire logic        ea_index_fault,
	input wire logic        io_valid,
	input wire logic [31:0] io_port,
	input wire logic [2:0]  io_size,
	input wire logic        io_cfg_index_sel,
	input wire logic        insn_retire,
	input wire logic        trace_flag,
	input wire logic        swint_valid,
	input wire logic [7:0]  swint_vector,
	input wire logic        task_switch,
	input wire logic        task_trap_bit,
	input wire logic        dr_wr,
	input wire logic        dr_rd,
	input wire logic [2:0]  dr_sel,
	input wire logic        dr_ack,
	input wire logic        dr_guard_fault,
	input wire logic        debug_exc,
	input wire logic        debug_exc_before,
	input wire logic [31:0] debug_cause_status
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence no_status_write;
		!(dr_wr && dr_sel == `DR_SEL_STATUS);
	endsequence
	// Two quiet cycles allow for a copy register behind the status output
	property status_sticky;
		no_status_write ##1 no_status_write |=>
			(debug_cause_status & $past(debug_cause_status)) == $past(debug_cause_status);
	endproperty
	a_status_sticky: assert property (status_sticky) else $error("status bit cleared by hardware");
	a_ea_latency: assert property (ea_req |=> ea_done) else $error("offset answer late");
	a_sp_index: assert property (ea_req && ea_mode == EA_IDX_DISP && ea_index_sel == `GPR_STACK_PTR |=>
		ea_index_fault && effective_offset == $past(instruction_displacement)) else $error("stack index used");
	a_cfg_index: assert property (io_valid && io_port == `IO_CFG_INDEX_PORT && io_size == 3'h1 |=>
		io_cfg_index_sel) else $error("config index port missed");
	a_swint_trap: assert property (swint_valid && swint_vector == `BREAK_TRAP_VECTOR |=> debug_exc)
		else $error("breakpoint trap missed");
	a_trace_step: assert property (insn_retire && trace_flag |=> debug_exc && debug_cause_status[`STAT_STEP_BIT])
		else $error("single step missed");
	a_task_trap: assert property (task_switch && task_trap_bit |=> debug_exc && debug_cause_status[`STAT_TASK_BIT])
		else $error("task trap missed");
	a_dr_answer: assert property ((dr_wr || dr_rd) |=> dr_ack != dr_guard_fault)
		else $error("register move answer wrong");
	a_guard_fault: assert property (dr_guard_fault |-> debug_exc && debug_exc_before)
		else $error("guard refusal without exception");
endmodule // adu_props
bind addr_debug_unit adu_props chk (.mclk, .rst_n, .ea_req, .ea_mode, .ea_index_sel, .instruction_displacement,
	.ea_done, .effective_offset, .ea_index_fault, .io_valid, .io_port, .io_size, .io_cfg_index_sel, .insn_retire,
	.trace_flag, .swint_valid, .swint_vector, .task_switch, .task_trap_bit, .dr_wr, .dr_rd, .dr_sel, .dr_ack,
	.dr_guard_fault, .debug_exc, .debug_exc_before, .debug_cause_status);

/* test/bus_model.sv */
// Bus unit model issuing linear accesses
`timescale 1ns/10ps
module bus_model
	import addr_debug_pkg::*;
(
	input wire logic mclk,
	access_if.src    acc
);
	initial begin
		acc.valid = 1'b0;
		acc.kind = ACC_EXEC;
		acc.addr = 32'h0000_0000;
		acc.size = 3'h1;
	end
	task automatic issue(input acc_kind_t k, input logic [31:0] a, input logic [2:0] z);
		@(posedge mclk) #1;
		acc.valid = 1'b1;
		acc.kind = k;
		acc.addr = a;
		acc.size = z;
		@(posedge mclk) #1;
		acc.valid = 1'b0;
		// Scramble released address and size so nothing leans on stale values; kind is held
		acc.addr = ~a;
		acc.size = ~z;
	endtask
endmodule // bus_model

/* test/testbench.sv */
// Self-checking bench for the address and debug unit
`timescale 1ns/10ps
`include "addr_debug_consts.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
	$display("wrong value %s expected %h seen %h", n, e, g); end end
module testbench;
	import addr_debug_pkg::*;
	logic mclk = 0, rst_n = 0, ea_req = 0, io_valid = 0, insn_retire = 0, trace_flag = 0, rd_pend = 0;
	logic swint_valid = 0, task_switch = 0, task_trap_bit = 0, dr_wr = 0, dr_rd = 0;
	ea_mode_t ea_mode = EA_DISP;
	logic [2:0] ea_base_sel = 0, ea_index_sel = 0, io_size = 1, dr_sel = 0;
	logic [1:0] index_multiplier = 0;
	logic [7:0] swint_vector = 0, mem_byte_en;
	logic [31:0] instruction_displacement = 0, io_port = 0, dr_wdata = 0, effective_offset, mem_phys_addr;
	logic [31:0] dr_rdata, debug_cause_status, st, ctl, seed = 32'h8cac;
	logic [255:0] gpr_values = 0;
	logic ea_done, ea_index_fault, mem_done, mem_split, mem_size_fault, io_done, io_range_fault;
	logic io_cfg_index_sel, io_cfg_data_sel, dr_ack, dr_guard_fault, debug_exc, debug_exc_before;
	logic [41:0] e;
	int num_errors = 0, comparisons = 0;
	logic [32:0] q_ea[$], q_exc[$];
	logic [31:0] q_rd[$];
	logic [41:0] q_mem[$];
	logic [2:0] q_io[$];
	access_if bif ();
	bus_model bus (.mclk, .acc(bif));
	addr_debug_unit uut (.mclk, .rst_n, .ea_req, .ea_mode, .ea_base_sel, .ea_index_sel, .index_multiplier,
		.instruction_displacement, .gpr_values, .ea_done, .effective_offset, .ea_index_fault,
		.acc_valid(bif.valid), .acc_kind(bif.kind), .acc_addr(bif.addr), .acc_size(bif.size), .mem_done,
		.mem_phys_addr, .mem_byte_en, .mem_split, .mem_size_fault, .io_valid, .io_port, .io_size, .io_done,
		.io_range_fault, .io_cfg_index_sel, .io_cfg_data_sel, .insn_retire, .trace_flag, .swint_valid,
		.swint_vector, .task_switch, .task_trap_bit, .dr_wr, .dr_rd, .dr_sel, .dr_wdata, .dr_ack, .dr_rdata,
		.dr_guard_fault, .debug_exc, .debug_exc_before, .debug_cause_status);
	always #4 mclk = ~mclk;
	always @(negedge mclk) begin
		if (ea_done === 1'b1) begin
			e = q_ea.pop_front();
			`CHK("offset", e[32:0], {ea_index_fault, effective_offset})
		end
		if (mem_done === 1'b1) begin
			e = q_mem.pop_front();
			`CHK("access", e, {mem_size_fault, mem_split, mem_byte_en, mem_phys_addr})
		end
		if (io_done === 1'b1) begin
			e = q_io.pop_front();
			`CHK("port", e[2:0], {io_range_fault, io_cfg_index_sel, io_cfg_data_sel})
		end
		if (debug_exc === 1'b1) begin
			e = q_exc.pop_front();
			`CHK("exception", e[32:0], {debug_exc_before, debug_cause_status})
		end
		if (dr_ack === 1'b1 && rd_pend) begin
			rd_pend = 0;
			e = q_rd.pop_front();
			`CHK("register", e[31:0], dr_rdata)
		end
	end
	task automatic close_out;
		// A result that never showed up leaves its note behind
		num_errors += q_ea.size() + q_mem.size() + q_exc.size() + q_rd.size() + q_io.size();
		if (num_errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic dr(input logic w, input logic [2:0] s, input logic [31:0] d, input logic chk);
		@(posedge mclk) #1;
		dr_wr = w;
		dr_rd = !w;
		dr_sel = s;
		dr_wdata = d;
		if (!w && chk) begin
			rd_pend = 1;
			q_rd.push_back(d);
		end
		@(posedge mclk) #1;
		dr_wr = 0;
		dr_rd = 0;
	endtask
	task automatic ea(input ea_mode_t m, input logic [2:0] b, input logic [2:0] x, input logic [1:0] s);
		logic hb, hx, hs, hd;
		logic [31:0] xv, r;
		@(posedge mclk) #1;
		ea_req = 1;
		ea_mode = m;
		ea_base_sel = b;
		ea_index_sel = x;
		index_multiplier = s;
		instruction_displacement = $random(seed);
		hb = m inside {EA_BASE, EA_BASE_DISP, EA_BASE_IDX, EA_BASE_SIDX, EA_BASE_IDX_DISP, EA_BASE_SIDX_DISP};
		hx = m >= EA_IDX_DISP;
		hs = m inside {EA_SIDX_DISP, EA_BASE_SIDX, EA_BASE_SIDX_DISP};
		hd = !(m inside {EA_BASE, EA_BASE_IDX, EA_BASE_SIDX});
		xv = (x == `GPR_STACK_PTR) ? 32'h0000_0000 : gpr_values[x * 32 +: 32];
		r = (hb ? gpr_values[b * 32 +: 32] : 32'h0) + (hx ? xv << (hs ? s : 2'h0) : 32'h0);
		r = r + (hd ? instruction_displacement : 32'h0);
		q_ea.push_back({hx && x == `GPR_STACK_PTR, r});
		@(posedge mclk) #1;
		ea_req = 0;
	endtask
	task automatic acc(input acc_kind_t k, input logic [31:0] a, input logic [2:0] z);
		logic [7:0] be;
		be = ((z == 3'h1) ? 8'h01 : (z == 3'h2) ? 8'h03 : (z == 3'h4) ? 8'h0F : 8'h00) << a[1:0];
		q_mem.push_back({be == 8'h00, |be[7:4], be, a});
		bus.issue(k, a, z);
	endtask
	task automatic ev(input logic r, input logic s, input logic t, input logic [7:0] v);
		@(posedge mclk) #1;
		insn_retire = r;
		swint_valid = s;
		swint_vector = v;
		task_switch = t;
		@(posedge mclk) #1;
		insn_retire = 0;
		swint_valid = 0;
		task_switch = 0;
	endtask
	task automatic exc(input logic b, input logic [31:0] add);
		st = st | add;
		q_exc.push_back({b, st});
	endtask
	task automatic io(input logic [31:0] p, input logic [2:0] z, input logic [2:0] flags);
		@(posedge mclk) #1;
		io_valid = 1;
		io_port = p;
		io_size = z;
		q_io.push_back(flags);
		@(posedge mclk) #1;
		io_valid = 0;
	endtask
	initial begin
		#20000;
		num_errors++;
		close_out;
	end
	initial begin
		for (int i = 0; i < 8; i++)
			gpr_values[i * 32 +: 32] = $random(seed);
		repeat (12) @(posedge mclk);
		#1 rst_n = 1;
		st = 0;
		dr(0, `DR_SEL_STATUS, `STAT_RESET, 1);
		dr(0, `DR_SEL_CONTROL, `CTL_RESET, 1);
		dr(1, `DR_SEL_STATUS, 32'hFFFF_FFFF, 0);
		dr(0, `DR_SEL_STATUS, `STAT_WMASK, 1);
		dr(1, `DR_SEL_STATUS, 32'h0000_0000, 0);
		dr(0, 3'h5, 32'h0000_0000, 1);
		for (int i = 0; i < 18; i++)
			ea(ea_mode_t'(i % 9), 3'(i), 3'((i % 7 == 4) ? 7 : i % 7), 2'(i));
		ea(EA_IDX_DISP, 3'h0, `GPR_STACK_PTR, 2'h0);
		acc(ACC_READ, 32'hFFFF_FFFC, 3'h4);
		acc(ACC_WRITE, 32'h0000_1233, 3'h2);
		acc(ACC_READ, 32'h0000_0010, 3'h3);
		io(`IO_CFG_INDEX_PORT, 3'h1, 3'b010);
		io(`IO_CFG_DATA_PORT, 3'h1, 3'b001);
		io(32'h0000_FFFE, 3'h4, 3'b100);
		io(32'h0000_FFFC, 3'h4, 3'b000);
		io(32'hFFFF_FFFE, 3'h4, 3'b100);
		// Write-only 4-byte watch at 1000h, unarmed 1-byte read-or-write watch at 2000h
		ctl = 32'h030D_0002;
		dr(1, 3'h0, 32'h0000_1000, 0);
		dr(1, 3'h2, 32'h0000_2000, 0);
		dr(1, `DR_SEL_CONTROL, ctl, 0);
		acc(ACC_WRITE, 32'h0000_1004, 3'h1);
		acc(ACC_READ, 32'h0000_1000, 3'h4);
		acc(ACC_READ, 32'h0000_2000, 3'h1);
		acc(ACC_WRITE, 32'h0000_1002, 3'h2);
		exc(0, 32'h0000_0005);
		ev(1, 0, 0, 8'h00);
		dr(1, `DR_SEL_STATUS, 32'h0000_0000, 0);
		st = 0;
		ctl = ctl | 32'h0000_0004;
		dr(1, 3'h1, 32'h0000_3000, 0);
		dr(1, `DR_SEL_CONTROL, ctl, 0);
		exc(1, 32'h0000_0002);
		acc(ACC_EXEC, 32'h0000_3000, 3'h1);
		task_trap_bit = 1;
		exc(0, 32'h0000_8000);
		ev(0, 0, 1, 8'h00);
		task_trap_bit = 0;
		ctl = ctl & ~`CTL_LOCAL_MASK;
		dr(0, `DR_SEL_CONTROL, ctl, 1);
		trace_flag = 1;
		exc(0, 32'h0000_4000);
		ev(1, 0, 0, 8'h00);
		trace_flag = 0;
		exc(0, 32'h0000_0000);
		ev(0, 1, 0, `BREAK_TRAP_VECTOR);
		ev(0, 1, 0, 8'h04);
		dr(1, `DR_SEL_CONTROL, ctl | 32'h0000_2000, 0);
		exc(1, 32'h0000_0000);
		dr(0, `DR_SEL_CONTROL, 32'h0000_0000, 0);
		dr(0, `DR_SEL_CONTROL, ctl, 1);
		dr(0, `DR_SEL_STATUS, st, 1);
		repeat (4) @(posedge mclk);
		close_out;
	end
endmodule // testbench
